/* src/busmux_pkg.sv */
// constants shared by the parameterised bus multiplexer
`default_nettype none
package busmux_pkg;
  // number of data inputs and the format of each one
  localparam int N_IN = 4;
  localparam int IN_L [N_IN] = '{8, 4, 6, 1};
  localparam int IN_R [N_IN] = '{0, 4, 2, 0};
  localparam bit IN_SIGNED [N_IN] = '{1'b1, 1'b1, 1'b0, 1'b0};

  // output pipeline depth
  localparam int STAGES = 2;

  function automatic int max_of(input int a [N_IN]);
    int m;
    m = 0;
    for (int i = 0; i < N_IN; i++) begin
      if (a[i] > m) begin
        m = a[i];
      end
    end
    return m;
  endfunction

  localparam int OUT_L = max_of(IN_L);
  localparam int OUT_R = max_of(IN_R);
  localparam int OUT_W = OUT_L + OUT_R;

  // select bus: one line per input, binary mode reads the low bits
  localparam int SEL_W = N_IN;
  localparam int IDX_W = $clog2(N_IN);

  // register port
  localparam int ADDR_W = 8;
  localparam int REG_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam int CTRL_ONEHOT_POS = 0;
  localparam int CTRL_USE_ENA_POS = 1;
  localparam int CTRL_USE_CLR_POS = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam int STATUS_BAD_POS = 0;
  localparam int STATUS_IDX_POS = 4;
endpackage
`default_nettype wire

/* src/bus_mux.sv */
// n-to-1 bus multiplexer with format alignment and optional output pipeline
`default_nettype none
module bus_mux (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // datapath
  input wire logic [busmux_pkg::SEL_W-1:0] SEL,
  input wire logic [busmux_pkg::IN_L[0]+busmux_pkg::IN_R[0]-1:0] DATA0,
  input wire logic [busmux_pkg::IN_L[1]+busmux_pkg::IN_R[1]-1:0] DATA1,
  input wire logic [busmux_pkg::IN_L[2]+busmux_pkg::IN_R[2]-1:0] DATA2,
  input wire logic [busmux_pkg::IN_L[3]+busmux_pkg::IN_R[3]-1:0] DATA3,
  input wire logic ENA,
  input wire logic ACLR,
  output logic [busmux_pkg::OUT_W-1:0] DATA_OUT,
  // register port
  input wire logic [busmux_pkg::ADDR_W-1:0] ADDR,
  input wire logic [busmux_pkg::REG_W-1:0] WR_DATA,
  input wire logic WR,
  input wire logic RD,
  output logic [busmux_pkg::REG_W-1:0] RD_DATA
);
  import busmux_pkg::*;

  // widen one input to the output format, binary points lined up
  function automatic logic [OUT_W-1:0] align(input logic [OUT_W-1:0] raw, input int w, input int r,
                                             input bit sgn);
    logic [OUT_W-1:0] v;
    v = raw;
    for (int b = 0; b < OUT_W; b++) begin
      if (b >= w) begin
        v[b] = sgn & raw[w-1];
      end
    end
    return v << (OUT_R - r);
  endfunction

  // reset release through two flops
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // control register
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic onehot_mode;
  logic use_ena;
  logic use_clr;

  assign onehot_mode = ctrl[CTRL_ONEHOT_POS];
  assign use_ena = ctrl[CTRL_USE_ENA_POS];
  assign use_clr = ctrl[CTRL_USE_CLR_POS];

  // aligned inputs, zero-padded before alignment
  logic [OUT_W-1:0] ext_in [N_IN];

  assign ext_in[0] = align(OUT_W'(DATA0), IN_L[0] + IN_R[0], IN_R[0], IN_SIGNED[0]);
  assign ext_in[1] = align(OUT_W'(DATA1), IN_L[1] + IN_R[1], IN_R[1], IN_SIGNED[1]);
  assign ext_in[2] = align(OUT_W'(DATA2), IN_L[2] + IN_R[2], IN_R[2], IN_SIGNED[2]);
  assign ext_in[3] = align(OUT_W'(DATA3), IN_L[3] + IN_R[3], IN_R[3], IN_SIGNED[3]);

  // selection
  logic [OUT_W-1:0] mux_val;
  logic sel_bad;
  logic [IDX_W-1:0] sel_idx;

  always_comb begin
    mux_val = '0;
    sel_bad = 1'b0;
    sel_idx = '0;
    if (onehot_mode) begin
      for (int i = 0; i < N_IN; i++) begin
        if (SEL[i]) begin
          mux_val = mux_val | ext_in[i];
          sel_idx = IDX_W'(i);
        end
      end
      // zero or several hot bits do not name an input
      sel_bad = ($countones(SEL) != 1);
    end else begin
      // select is read as an unsigned index, no fraction
      sel_idx = SEL[IDX_W-1:0];
      if (int'(sel_idx) < N_IN) begin
        mux_val = ext_in[sel_idx];
      end else begin
        sel_bad = 1'b1;
      end
    end
  end

  // pipeline
  logic stage_en;
  logic clr_now;

  assign stage_en = !use_ena || ENA;
  // clear is a raw asynchronous pin; its release is not synchronised, unlike the reset, whose release passes through two flops
  assign clr_now = use_clr && ACLR;

  generate
    if (STAGES > 0) begin : g_pipe
      logic [OUT_W-1:0] pipe [STAGES];
      logic [OUT_W-1:0] next_pipe [STAGES];

      always_comb begin
        for (int s = 0; s < STAGES; s++) begin
          next_pipe[s] = pipe[s];
        end
        if (stage_en) begin
          next_pipe[0] = mux_val;
          for (int s = 1; s < STAGES; s++) begin
            next_pipe[s] = pipe[s-1];
          end
        end
      end

      always_ff @(posedge CLK or negedge rst_n or posedge clr_now) begin
        if (!rst_n || clr_now) begin
          for (int s = 0; s < STAGES; s++) begin
            pipe[s] <= '0;
          end
        end else begin
          for (int s = 0; s < STAGES; s++) begin
            pipe[s] <= next_pipe[s];
          end
        end
      end

      assign DATA_OUT = pipe[STAGES-1];
    end else begin : g_comb
      // with no stages the output is combinational and enable and clear do nothing
      assign DATA_OUT = mux_val;
    end
  endgenerate

  // register port
  logic [REG_W-1:0] next_rd_data;
  logic [REG_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[STATUS_BAD_POS] = sel_bad;
    status_word[STATUS_IDX_POS +: IDX_W] = sel_idx;
  end

  always_comb begin
    next_ctrl = ctrl;
    next_rd_data = '0;
    if (WR && ADDR == CTRL_OFS) begin
      next_ctrl = WR_DATA[CTRL_W-1:0];
    end
    if (RD) begin
      case (ADDR)
        CTRL_OFS: next_rd_data = REG_W'(ctrl);
        STATUS_OFS: next_rd_data = status_word;
        default: next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      RD_DATA <= '0;
    end else begin
      ctrl <= next_ctrl;
      RD_DATA <= next_rd_data;
    end
  end

  // input count must exceed one
  localparam int COUNT_OK = (N_IN > 1) ? 1 : 0;

  a_count_valid: assert property (@(posedge CLK) COUNT_OK == 1)
    else $error("input count must be above one");

  a_width_exact: assert property (@(posedge CLK) disable iff (!rst_n)
    $bits(DATA_OUT) == OUT_L + OUT_R)
    else $error("output width differs from format maxima");

  a_binary_route: assert property (@(posedge CLK) disable iff (!rst_n)
    (!onehot_mode && SEL[IDX_W-1:0] == 2'h1) |-> mux_val == ext_in[1])
    else $error("binary select did not route input one");

  a_onehot_route: assert property (@(posedge CLK) disable iff (!rst_n)
    (onehot_mode && SEL == 4'h4) |-> (mux_val == ext_in[2] && !sel_bad))
    else $error("one-hot select did not route input two");

  a_sign_fill: assert property (@(posedge CLK) disable iff (!rst_n)
    (!onehot_mode && SEL[IDX_W-1:0] == 2'h0) |->
      mux_val[OUT_W-1:OUT_R+IN_L[0]-1] == {(OUT_L-IN_L[0]+1){DATA0[IN_L[0]-1]}})
    else $error("signed input not extended from its msb");

  a_zero_fill: assert property (@(posedge CLK) disable iff (!rst_n)
    (!onehot_mode && SEL[IDX_W-1:0] == 2'h2) |->
      mux_val == {{(OUT_L-IN_L[2]){1'b0}}, DATA2, {(OUT_R-IN_R[2]){1'b0}}})
    else $error("unsigned input misaligned or extended wrongly");

  a_bad_select: assert property (@(posedge CLK) disable iff (!rst_n)
    (onehot_mode && SEL == 4'h3) |-> sel_bad)
    else $error("two hot bits not flagged");

  sequence s_two_enabled;
    (stage_en && !clr_now) ##1 (stage_en && !clr_now);
  endsequence

  // a clear landing between the two loads and the check would zero the output, so it is excluded
  a_latency_two: assert property (@(posedge CLK) disable iff (!rst_n)
    s_two_enabled ##1 !clr_now |-> DATA_OUT == $past(mux_val, 2))
    else $error("output not two enabled cycles behind select");

  a_hold_disabled: assert property (@(posedge CLK) disable iff (!rst_n)
    (!stage_en && !clr_now) ##1 !clr_now |-> $stable(DATA_OUT))
    else $error("output moved while enable low");

  a_clear_empties: assert property (@(posedge CLK) disable iff (!rst_n)
    clr_now |-> DATA_OUT == '0)
    else $error("clear did not empty the pipeline");

  a_clear_ignored: assert property (@(posedge CLK) disable iff (!rst_n)
    (!use_clr && ACLR && stage_en) |=> DATA_OUT == $past(g_pipe.pipe[STAGES-2]))
    else $error("clear acted while not selected");

  a_ctrl_steers: assert property (@(posedge CLK) disable iff (!rst_n)
    (WR && ADDR == CTRL_OFS) |=> ctrl == $past(WR_DATA[CTRL_W-1:0]))
    else $error("control write not stored");

  a_read_next: assert property (@(posedge CLK) disable iff (!rst_n)
    (RD && ADDR == STATUS_OFS) |=> RD_DATA == $past(status_word))
    else $error("status read data wrong");

  // full-value routing for the integer, fraction and single-bit inputs (0, 1 and 3)
  a_route_int: assert property (@(posedge CLK) disable iff (!rst_n)
    (!onehot_mode && SEL[IDX_W-1:0] == 2'h0) |-> mux_val == {DATA0, {OUT_R{1'b0}}})
    else $error("integer input not placed above the fraction");

  a_route_frac: assert property (@(posedge CLK) disable iff (!rst_n)
    (!onehot_mode && SEL[IDX_W-1:0] == 2'h1) |-> mux_val == {{(OUT_L-IN_L[1]){DATA1[7]}}, DATA1})
    else $error("signed fraction not extended from its msb");

  a_route_bit: assert property (@(posedge CLK) disable iff (!rst_n)
    (!onehot_mode && SEL[IDX_W-1:0] == 2'h3) |-> mux_val == {{(OUT_L-1){1'b0}}, DATA3, {OUT_R{1'b0}}})
    else $error("single bit input misplaced");

  // binary mode reads only the low select bits
  a_binary_high: assert property (@(posedge CLK) disable iff (!rst_n)
    (!onehot_mode && SEL == 4'h8) |-> (mux_val == {DATA0, {OUT_R{1'b0}}} && !sel_bad))
    else $error("upper select bits disturbed binary routing");

  a_onehot_top: assert property (@(posedge CLK) disable iff (!rst_n)
    (onehot_mode && SEL == 4'h8) |-> mux_val == {{(OUT_L-1){1'b0}}, DATA3, {OUT_R{1'b0}}})
    else $error("one-hot select did not route input three");

  a_status_index: assert property (@(posedge CLK) disable iff (!rst_n)
    (onehot_mode && SEL == 4'h8) |-> (sel_idx == IDX_W'(3) && !sel_bad))
    else $error("decoded index wrong for top input");

  a_onehot_none: assert property (@(posedge CLK) disable iff (!rst_n)
    (onehot_mode && SEL == 4'h0) |-> (mux_val == '0 && sel_bad))
    else $error("empty one-hot select not flagged");

  a_onehot_pair: assert property (@(posedge CLK) disable iff (!rst_n)
    (onehot_mode && SEL == 4'h3) |->
      (mux_val == ({DATA0, {OUT_R{1'b0}}} | {{(OUT_L-IN_L[1]){DATA1[7]}}, DATA1}) && sel_idx == IDX_W'(1)))
    else $error("two hot bits did not merge their inputs");

  // the clear acts between edges, so its release shows one sample later
  sequence s_clear_drop;
    clr_now ##1 !clr_now;
  endsequence

  a_clear_release: assert property (@(posedge CLK) disable iff (!rst_n)
    s_clear_drop |-> DATA_OUT == '0)
    else $error("pipeline not empty when clear released");

  sequence s_load_once;
    (stage_en && !clr_now) ##1 !clr_now;
  endsequence

  a_stage_load: assert property (@(posedge CLK) disable iff (!rst_n)
    s_load_once |-> g_pipe.pipe[0] == $past(mux_val))
    else $error("first stage did not load on an enabled edge");
endmodule
`default_nettype wire

/* test/datapath_src.sv */
// source model for the datapath logic that feeds the multiplexer
`default_nettype none
module datapath_src (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic [3:0] sel_req,
  input wire logic flip,
  // drive toward the multiplexer
  output logic [3:0] sel,
  output logic [7:0] d0,
  output logic [7:0] d1,
  output logic [7:0] d2,
  output logic d3
);
  timeunit 1ns;
  timeprecision 1ps;
  // negative patterns by default so extension of the sign shows
  always_ff @(posedge clk) begin
    sel <= sel_req;
    d0 <= 8'h9c ^ {8{flip}};
    d1 <= 8'ha5 ^ {8{flip}};
    d2 <= 8'hc3 ^ {8{flip}};
    d3 <= ~flip;
  end
endmodule
`default_nettype wire

/* test/param_bus_multiplexer_bench.sv */
// self-checking bench for the bus multiplexer
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module param_bus_multiplexer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import busmux_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, ENA = 1'b1, ACLR = 1'b0, WR = 1'b0, RD = 1'b0, flip = 1'b0;
  logic [3:0] SEL, sel_req = 4'h1;
  logic [7:0] D0, D1, D2, ADDR = 8'h00;
  logic D3;
  logic [REG_W-1:0] WR_DATA = '0, RD_DATA, rdv;
  logic [OUT_W-1:0] DATA_OUT, last;
  int failures = 0, samples_checked = 0;
  always #4 CLK = ~CLK;
  datapath_src src (.clk(CLK), .sel_req(sel_req), .flip(flip), .sel(SEL), .d0(D0), .d1(D1),
    .d2(D2), .d3(D3));
  bus_mux dut (.CLK(CLK), .RST_N(RST_N), .SEL(SEL), .DATA0(D0), .DATA1(D1), .DATA2(D2),
    .DATA3(D3), .ENA(ENA), .ACLR(ACLR), .DATA_OUT(DATA_OUT), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR(WR), .RD(RD), .RD_DATA(RD_DATA));
  // expected output worked out from each input's own format
  function automatic logic [OUT_W-1:0] align(int i, bit f);
    logic [7:0] d0, d1, d2;
    d0 = 8'h9c ^ {8{f}};
    d1 = 8'ha5 ^ {8{f}};
    d2 = 8'hc3 ^ {8{f}};
    case (i)
      0: return {d0, 4'h0};
      1: return {{4{d1[7]}}, d1};
      2: return {2'b00, d2, 2'b00};
      default: return {7'h00, ~f, 4'h0};
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 rdv = RD_DATA;
  endtask
  // source registers one edge, then the two pipeline stages
  task automatic put(input logic [3:0] s, input bit f);
    @(posedge CLK);
    sel_req <= s;
    flip <= f;
    repeat (3) @(posedge CLK);
    #1;
  endtask
  task automatic t_binary;
    for (int i = 0; i < 4; i++) begin
      for (int f = 0; f < 2; f++) begin
        put(4'(i), f[0]);
        `CHK("binary out", align(i, f[0]), DATA_OUT)
      end
    end
  endtask
  task automatic t_regs;
    rd(CTRL_OFS);
    `CHK("ctrl reset", 32'h0000_0000, rdv)
    rd(8'h08);
    `CHK("unmapped read", 32'h0000_0000, rdv)
  endtask
  task automatic t_onehot;
    wr(CTRL_OFS, 32'hffff_fff9);
    rd(CTRL_OFS);
    `CHK("ctrl readback", 32'h0000_0001, rdv)
    put(4'h3, 1'b0);
    `CHK("pair out", align(0, 1'b0) | align(1, 1'b0), DATA_OUT)
    rd(STATUS_OFS);
    `CHK("pair status", 32'h0000_0011, rdv)
    put(4'h0, 1'b0);
    `CHK("no hot out", 12'h000, DATA_OUT)
    rd(STATUS_OFS);
    `CHK("none status", 32'h0000_0001, rdv)
    for (int i = 0; i < 4; i++) begin
      put(4'h1 << i, 1'b0);
      `CHK("onehot out", align(i, 1'b0), DATA_OUT)
      rd(STATUS_OFS);
      `CHK("onehot status", 32'(i) << 4, rdv)
    end
    last = align(3, 1'b0);
  endtask
  task automatic t_enable;
    wr(CTRL_OFS, 32'h0000_0002);
    @(posedge CLK);
    ENA <= 1'b0;
    put(4'h1, 1'b1);
    `CHK("held out", last, DATA_OUT)
    @(posedge CLK);
    ENA <= 1'b1;
    repeat (2) @(posedge CLK);
    #1 `CHK("enabled out", align(1, 1'b1), DATA_OUT)
    // clear pin raised while the control word leaves it unused
    #2 ACLR = 1'b1;
    @(posedge CLK);
    #1 `CHK("clear ignored", align(1, 1'b1), DATA_OUT)
    ACLR = 1'b0;
  endtask
  // clear is raised away from the edge: it is asynchronous and its release is not resynchronised
  task automatic t_clear;
    wr(CTRL_OFS, 32'h0000_0004);
    @(posedge CLK);
    #3 ACLR = 1'b1;
    #1 `CHK("cleared out", 12'h000, DATA_OUT)
    @(posedge CLK);
    #1 `CHK("clear holds", 12'h000, DATA_OUT)
    #2 ACLR = 1'b0;
    put(4'h0, 1'b0);
    `CHK("after clear", align(0, 1'b0), DATA_OUT)
  endtask
  task automatic report_and_stop;
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_regs();
    t_binary();
    t_onehot();
    t_enable();
    t_clear();
    report_and_stop();
  end
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
